// file: rtl/ccg_top.v
// top of the clock source and generator control block
// assumes all clock sources arrive as levels sampled by mclk
`include "ccg_map.vh"
`timescale 1ns/10ps
`default_nettype none
module ccg_top #(
  parameter DIV_W     = 8,
  parameter CFG_W     = 8,
  parameter FC_W      = 16,
  parameter RECOV_CYC = `CCG_RECOV_NS / `CCG_CLK_PERIOD_NS,
  parameter FC_CYC    = `CCG_FC_WINDOW_NS / `CCG_CLK_PERIOD_NS
) (
  input  wire                        mclk,
  input  wire                        rst_n,
  input  wire                        ring_osc_source,
  input  wire                        crystal_osc_source,
  input  wire                        gpin0,
  input  wire                        gpin1,
  input  wire                        pll_sys_clk,
  input  wire                        pll_usb_clk,
  input  wire [3*`CCG_NUM_GEN-1:0]   gen_sel,
  input  wire [DIV_W*`CCG_NUM_GEN-1:0] gen_div,
  input  wire [`CCG_NUM_GEN-1:0]     gen_enable,
  input  wire [`CCG_NUM_GEN-1:0]     gen_sleep_gate,
  input  wire                        sleep,
  input  wire                        deep_lowpower_mode_req,
  input  wire                        rtc_alarm,
  input  wire                        gpio_wake,
  input  wire                        ring_osc_stop,
  input  wire                        ring_osc_cfg_load,
  input  wire [CFG_W-1:0]            ring_osc_cfg_in,
  input  wire                        crystal_osc_enable,
  input  wire                        fc_start,
  input  wire [2:0]                  fc_src,
  input  wire                        recov_clear,
  output reg                         ring_osc_run_ff,
  output reg  [CFG_W-1:0]            ring_osc_cfg_ff,
  output reg                         crystal_osc_run_ff,
  output reg                         pll_ref_ff,
  output reg                         deep_lowpower_mode_ff,
  output wire                        clk_ref,
  output wire                        clk_sys,
  output wire [3:0]                  gpio_clock_outputs,
  output reg  [FC_W-1:0]             fc_count_ff,
  output reg                         fc_done_ff,
  output reg                         recov_flag_ff
);
  // ----------------------------------------------------------
  // source levels
  // ----------------------------------------------------------
  wire [`CCG_NUM_GEN-1:0] gen_clk;
  wire [7:0]              src_lvl;
  wire                    ring_lvl;
  wire                    xtal_lvl;
  reg                     recov_force;

  assign ring_lvl = ring_osc_source & ring_osc_run_ff;
  assign xtal_lvl = crystal_osc_source & crystal_osc_run_ff;
  // external pins pass untouched by deep low-power mode
  assign src_lvl  = {gen_clk[`CCG_GEN_REF], gen_clk[`CCG_GEN_SYS], pll_usb_clk, pll_sys_clk,
                     gpin1, gpin0, xtal_lvl, ring_lvl};

  assign clk_ref            = gen_clk[`CCG_GEN_REF];
  assign clk_sys            = gen_clk[`CCG_GEN_SYS];
  assign gpio_clock_outputs = gen_clk[`CCG_GEN_GP0+3:`CCG_GEN_GP0];

  // ----------------------------------------------------------
  // generators
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CCG_NUM_GEN; g = g + 1) begin : gen_blk
      ccg_gen #(
        .SRC_MASK (g == `CCG_GEN_REF ? `CCG_MASK_REF :
                   g == `CCG_GEN_SYS ? `CCG_MASK_SYS : `CCG_MASK_GPOUT),
        .DIV_W    (DIV_W)
      ) u_gen (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .src_lvl    (src_lvl),
        .sel        (gen_sel[3*g+2:3*g]),
        .div        (gen_div[DIV_W*g+DIV_W-1:DIV_W*g]),
        .enable     (gen_enable[g]),
        .sleep      (sleep),
        .sleep_gate (gen_sleep_gate[g]),
        .force_sel  (recov_force && g == `CCG_GEN_SYS),
        .force_val  (`CCG_SRC_RING),
        .clk_o      (gen_clk[g]),
        .cur_sel_ff ()
      );
    end
  endgenerate

  // ----------------------------------------------------------
  // oscillators and deep low-power mode
  // ----------------------------------------------------------
  wire wake;
  assign wake = rtc_alarm | gpio_wake;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deep_lowpower_mode_ff <= 1'b0;
      ring_osc_run_ff       <= 1'b1;
      ring_osc_cfg_ff       <= {CFG_W{1'b0}};
      crystal_osc_run_ff    <= 1'b0;
      pll_ref_ff            <= 1'b0;
    end else begin
      if (wake)
        deep_lowpower_mode_ff <= 1'b0;
      else if (deep_lowpower_mode_req)
        deep_lowpower_mode_ff <= 1'b1;
      // sleep has no effect here; recovery overrides a software stop
      ring_osc_run_ff    <= ~deep_lowpower_mode_ff & (~ring_osc_stop | recov_force | recov_flag_ff);
      crystal_osc_run_ff <= crystal_osc_enable & ~deep_lowpower_mode_ff;
      if (ring_osc_cfg_load)
        ring_osc_cfg_ff <= ring_osc_cfg_in;
      pll_ref_ff <= xtal_lvl;
    end
  end

  // ----------------------------------------------------------
  // system clock recovery
  // ----------------------------------------------------------
  reg        sys_prev_ff;
  reg [31:0] recov_cnt_ff;
  wire       sys_rise;
  assign sys_rise = clk_sys & ~sys_prev_ff;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_prev_ff   <= 1'b0;
      recov_cnt_ff  <= 32'h0;
      recov_force   <= 1'b0;
      recov_flag_ff <= 1'b0;
    end else begin
      sys_prev_ff <= clk_sys;
      recov_force <= 1'b0;
      // a clock gated on purpose in light low-power mode is not a stopped clock
      if (sys_rise || !gen_enable[`CCG_GEN_SYS] || deep_lowpower_mode_ff ||
          (sleep && gen_sleep_gate[`CCG_GEN_SYS])) begin
        recov_cnt_ff <= 32'h0;
      end else if (recov_cnt_ff >= RECOV_CYC - 1) begin
        recov_cnt_ff <= 32'h0;
        recov_force  <= 1'b1;
      end else begin
        recov_cnt_ff <= recov_cnt_ff + 32'h1;
      end
      if (recov_force)
        recov_flag_ff <= 1'b1;
      else if (recov_clear)
        recov_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // frequency counter
  // ----------------------------------------------------------
  reg            fc_busy_ff;
  reg            fc_prev_ff;
  reg [31:0]     fc_win_ff;
  reg [FC_W-1:0] fc_acc_ff;
  wire           fc_lvl;
  assign fc_lvl = src_lvl[fc_src];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fc_busy_ff  <= 1'b0;
      fc_prev_ff  <= 1'b0;
      fc_win_ff   <= 32'h0;
      fc_acc_ff   <= {FC_W{1'b0}};
      fc_count_ff <= {FC_W{1'b0}};
      fc_done_ff  <= 1'b0;
    end else begin
      fc_prev_ff <= fc_lvl;
      if (fc_start && !fc_busy_ff) begin
        fc_busy_ff <= 1'b1;
        fc_done_ff <= 1'b0;
        fc_win_ff  <= 32'h0;
        fc_acc_ff  <= {FC_W{1'b0}};
      end else if (fc_busy_ff) begin
        if (fc_lvl && !fc_prev_ff && fc_acc_ff != {FC_W{1'b1}})
          fc_acc_ff <= fc_acc_ff + 1'b1;
        if (fc_win_ff >= FC_CYC - 1) begin
          fc_busy_ff  <= 1'b0;
          fc_done_ff  <= 1'b1;
          fc_count_ff <= fc_acc_ff + ((fc_lvl && !fc_prev_ff && fc_acc_ff != {FC_W{1'b1}}) ? 1'b1 : 1'b0);
        end else begin
          fc_win_ff <= fc_win_ff + 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/ccg_map.vh
// constants of the clock source and generator control block
// assumes a single 100 MHz mclk domain
`ifndef CCG_MAP_VH
`define CCG_MAP_VH
// ----------------------------------------------------------
// source indices
// ----------------------------------------------------------
`define CCG_SRC_RING      3'h0
`define CCG_SRC_CRYSTAL   3'h1
`define CCG_SRC_GPIN0     3'h2
`define CCG_SRC_GPIN1     3'h3
`define CCG_SRC_PLL_SYS   3'h4
`define CCG_SRC_PLL_USB   3'h5
`define CCG_SRC_CLK_SYS   3'h6
`define CCG_SRC_CLK_REF   3'h7
// ----------------------------------------------------------
// per-generator allowed source masks
// ----------------------------------------------------------
`define CCG_MASK_REF      8'h0f
`define CCG_MASK_SYS      8'h3f
`define CCG_MASK_GPOUT    8'hff
// ----------------------------------------------------------
// generator indices
// ----------------------------------------------------------
`define CCG_GEN_REF       0
`define CCG_GEN_SYS       1
`define CCG_GEN_GP0       2
`define CCG_NUM_GEN       6
// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define CCG_CLK_PERIOD_NS 10
`define CCG_RECOV_NS      2000
`define CCG_FC_WINDOW_NS  10000
`endif

// file: rtl/ccg_gen.v
// one clock generator: source select, divider, gating
// assumes source levels are sampled in the mclk domain
`timescale 1ns/10ps
`include "ccg_map.vh"
`default_nettype none
module ccg_gen #(
  parameter [7:0] SRC_MASK = 8'hff,
  parameter       DIV_W    = 8
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [7:0]       src_lvl,
  input  wire [2:0]       sel,
  input  wire [DIV_W-1:0] div,
  input  wire             enable,
  input  wire             sleep,
  input  wire             sleep_gate,
  input  wire             force_sel,
  input  wire [2:0]       force_val,
  output reg              clk_o,
  output reg  [2:0]       cur_sel_ff
);
  // ----------------------------------------------------------
  // switch states
  // ----------------------------------------------------------
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_SWAP = 3'b100;

  reg [2:0]       state_ff;
  reg [2:0]       nxt_state;
  reg             prev_ff;
  reg             armed_ff;
  reg             div_lvl_ff;
  reg [DIV_W-1:0] cnt_ff;
  wire            cur_lvl;
  wire            rise;
  wire            sel_ok;
  wire            active;
  wire            gen_lvl;

  assign cur_lvl = src_lvl[cur_sel_ff];
  assign rise    = cur_lvl & ~prev_ff;
  assign sel_ok  = SRC_MASK[sel];
  assign active  = enable & ~(sleep & sleep_gate) & (state_ff == ST_RUN) & armed_ff;
  assign gen_lvl = (div == {DIV_W{1'b0}}) ? cur_lvl : div_lvl_ff;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:  if (sel_ok && sel != cur_sel_ff) nxt_state = ST_WAIT;
      ST_WAIT: if (!clk_o) nxt_state = ST_SWAP;
      ST_SWAP: nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_RUN;
      cur_sel_ff <= `CCG_SRC_RING;
      prev_ff    <= 1'b0;
      armed_ff   <= 1'b1;
      div_lvl_ff <= 1'b0;
      cnt_ff     <= {DIV_W{1'b0}};
      clk_o      <= 1'b0;
    end else if (force_sel) begin
      state_ff   <= ST_RUN;
      cur_sel_ff <= force_val;
      prev_ff    <= 1'b1;
      armed_ff   <= 1'b0;
      div_lvl_ff <= 1'b0;
      cnt_ff     <= {DIV_W{1'b0}};
      clk_o      <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_SWAP) begin
        cur_sel_ff <= sel;
        // new source counts only from its first full high phase
        prev_ff    <= 1'b1;
        armed_ff   <= 1'b0;
        div_lvl_ff <= 1'b0;
        cnt_ff     <= {DIV_W{1'b0}};
      end else begin
        prev_ff <= cur_lvl;
        if (!cur_lvl)
          armed_ff <= 1'b1;
        if (rise) begin
          if (cnt_ff + 1'b1 >= div) begin
            cnt_ff     <= {DIV_W{1'b0}};
            div_lvl_ff <= ~div_lvl_ff;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      end
      // high phase is allowed to finish before holding low
      clk_o <= active ? gen_lvl : (clk_o & gen_lvl);
    end
  end
endmodule
`default_nettype wire

// file: bench/ccg_top_sva.sv
// assertions for the clock source and generator control top
// assumes binding into ccg_top, single mclk domain
`timescale 1ns/10ps
`default_nettype none
module ccg_top_sva #(
  parameter RECOV_CYC = 200,
  parameter FC_CYC    = 1000
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       sleep,
  input wire logic       rtc_alarm,
  input wire logic       gpio_wake,
  input wire logic       ring_osc_cfg_load,
  input wire logic       fc_start,
  input wire logic       recov_clear,
  input wire logic [5:0] gen_sleep_gate,
  input wire logic       ring_osc_run_ff,
  input wire logic [7:0] ring_osc_cfg_ff,
  input wire logic       crystal_osc_run_ff,
  input wire logic       pll_ref_ff,
  input wire logic       deep_lowpower_mode_ff,
  input wire logic       clk_sys,
  input wire logic       fc_done_ff,
  input wire logic       recov_flag_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  a_boot_ring_runs: assert property ($rose(rst_n) |-> ring_osc_run_ff)
    else $error("ring oscillator not running after reset");
  a_deep_halts_osc: assert property (deep_lowpower_mode_ff [*3] |-> !ring_osc_run_ff && !crystal_osc_run_ff)
    else $error("oscillator running in deep mode");
  a_wake_leaves_deep: assert property (deep_lowpower_mode_ff && (rtc_alarm || gpio_wake)
    |-> ##[1:3] !deep_lowpower_mode_ff) else $error("deep mode not left on wake");
  a_ring_cfg_kept: assert property (!$stable(ring_osc_cfg_ff)
    |-> $past(ring_osc_cfg_load) || $past(ring_osc_cfg_load, 2)) else $error("ring config changed unasked");
  a_pll_ref_off: assert property (!crystal_osc_run_ff [*3] |-> !pll_ref_ff)
    else $error("pll reference toggles without crystal");
  a_fc_done_time: assert property ($rose(fc_done_ff)
    |-> $past(fc_start, FC_CYC) || $past(fc_start, FC_CYC + 1) || $past(fc_start, FC_CYC + 2))
    else $error("frequency count window wrong");
  a_fc_done_holds: assert property (fc_done_ff && !fc_start |=> fc_done_ff)
    else $error("count done dropped");
  a_recov_sticky: assert property (recov_flag_ff && !recov_clear |=> recov_flag_ff)
    else $error("recovery flag dropped");
  a_recov_ring_on: assert property ($rose(recov_flag_ff) |-> ##[0:2] ring_osc_run_ff)
    else $error("recovery without ring oscillator");
  a_sleep_gates_sys: assert property ((sleep && gen_sleep_gate[1]) [*8] |-> !clk_sys)
    else $error("system clock runs in sleep");
  a_no_runt_pulse: assert property ($rose(clk_sys) |=> clk_sys)
    else $error("runt pulse on system clock");
endmodule
bind ccg_top ccg_top_sva #(.RECOV_CYC(RECOV_CYC), .FC_CYC(FC_CYC)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .sleep(sleep), .rtc_alarm(rtc_alarm), .gpio_wake(gpio_wake),
  .ring_osc_cfg_load(ring_osc_cfg_load), .fc_start(fc_start), .recov_clear(recov_clear),
  .gen_sleep_gate(gen_sleep_gate), .ring_osc_run_ff(ring_osc_run_ff), .ring_osc_cfg_ff(ring_osc_cfg_ff),
  .crystal_osc_run_ff(crystal_osc_run_ff), .pll_ref_ff(pll_ref_ff), .clk_sys(clk_sys),
  .deep_lowpower_mode_ff(deep_lowpower_mode_ff), .fc_done_ff(fc_done_ff), .recov_flag_ff(recov_flag_ff));
`default_nettype wire

// file: bench/ccg_src_model.sv
// model of the clock sources feeding the control block
// assumes ring, crystal and pll run enables come from the oscillator flags of the design; gpin0 always runs, gpin1 runs while hold_gp1 is low
`timescale 1ns/10ps
`default_nettype none
module ccg_src_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ring_run,
  input  wire logic       xtal_run,
  input  wire logic       hold_gp1,
  output var  logic [5:0] src_ff
);
  // ----------------------------------------------------------
  // ring, crystal, gpin0, gpin1, pll_sys, pll_usb
  // ----------------------------------------------------------
  localparam int HALF [6] = '{2, 3, 4, 5, 2, 3};
  logic [2:0] cnt_ff [6];
  logic [5:0] run;
  assign run = {xtal_run, xtal_run, ~hold_gp1, 1'b1, xtal_run, ring_run};
  always @(posedge mclk or negedge rst_n) begin
    for (int i = 0; i < 6; i++) begin
      if (!rst_n) begin
        cnt_ff[i] <= 3'h0;
        src_ff[i] <= 1'b0;
      end else if (run[i] || src_ff[i]) begin
        // a stopping source still ends its high phase
        cnt_ff[i] <= (cnt_ff[i] == 3'(HALF[i] - 1)) ? 3'h0 : cnt_ff[i] + 3'h1;
        if (cnt_ff[i] == 3'(HALF[i] - 1)) src_ff[i] <= ~src_ff[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/ccg_top_tb.sv
// self-checking bench of the clock source and generator control top
// assumes ccg_top, ccg_src_model and the bound checker
`include "ccg_map.vh"
`timescale 1ns/10ps
`default_nettype none
module ccg_top_tb;
  localparam RCY = 60;
  localparam FCY = 120;
  logic        mclk, rst_n, sleep, deep_lowpower_mode_req, rtc_alarm, gpio_wake, ring_osc_stop, cfg_load;
  logic        xtal_en, fc_start, recov_clear, hold_gp1;
  logic [7:0]  cfg_in;
  logic [2:0]  fc_src;
  logic [17:0] gen_sel;
  logic [47:0] gen_div;
  logic [5:0]  gen_enable, gen_sleep_gate;
  wire  [5:0]  src;
  wire         ring_run, xtal_run, deep, clk_sys, fc_done, recov, pll_ref, clk_ref;
  wire  [5:0]  obs;
  wire  [7:0]  cfg;
  wire  [3:0]  gpo;
  wire  [15:0] fc_cnt;
  logic [15:0] exp_q [$];
  logic        done_q = 1'b0;
  int          n_fail = 0, samples_checked = 0, d;
  int          per [8] = '{4, 6, 8, 10, 4, 6, 8, 6};
  always #5 mclk = ~mclk;
  assign obs = {clk_ref, pll_ref, gpo};
  ccg_src_model u_src (.mclk(mclk), .rst_n(rst_n), .ring_run(ring_run), .xtal_run(xtal_run),
    .hold_gp1(hold_gp1), .src_ff(src));
  ccg_top #(.RECOV_CYC(RCY), .FC_CYC(FCY)) dut (.mclk(mclk), .rst_n(rst_n), .ring_osc_source(src[0]),
    .crystal_osc_source(src[1]), .gpin0(src[2]), .gpin1(src[3]), .pll_sys_clk(src[4]), .pll_usb_clk(src[5]),
    .gen_sel(gen_sel), .gen_div(gen_div), .gen_enable(gen_enable), .gen_sleep_gate(gen_sleep_gate),
    .sleep(sleep), .deep_lowpower_mode_req(deep_lowpower_mode_req), .rtc_alarm(rtc_alarm), .gpio_wake(gpio_wake),
    .ring_osc_stop(ring_osc_stop), .ring_osc_cfg_load(cfg_load), .ring_osc_cfg_in(cfg_in),
    .crystal_osc_enable(xtal_en), .fc_start(fc_start), .fc_src(fc_src), .recov_clear(recov_clear),
    .ring_osc_run_ff(ring_run), .ring_osc_cfg_ff(cfg), .crystal_osc_run_ff(xtal_run), .pll_ref_ff(pll_ref),
    .deep_lowpower_mode_ff(deep), .clk_ref(clk_ref), .clk_sys(clk_sys), .gpio_clock_outputs(gpo),
    .fc_count_ff(fc_cnt), .fc_done_ff(fc_done), .recov_flag_ff(recov));
  task tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input logic tl);
    samples_checked++;
    if (got !== exp && !(tl && (got === exp + 16'h1 || got === exp - 16'h1))) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task run_fc(input int s, input int p);
    exp_q.push_back(16'(FCY / p));
    fc_src = 3'(s);
    fc_start = 1'b1;
    tick();
    fc_start = 1'b0;
    tick(2);
    repeat (FCY + 20) if (fc_done !== 1'b1) tick();
    chk(16'(fc_done), 16'h1, 1'b0);
    tick(2);
  endtask
  task count_rises(input int k, input int p);
    logic [15:0] n;
    logic        prv;
    n = 16'h0;
    prv = obs[k];
    repeat (40) begin
      tick();
      if (obs[k] === 1'b1 && prv === 1'b0) n++;
      prv = obs[k];
    end
    chk(n, 16'(40 / p), 1'b1);
  endtask
  // ----------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------
  always @(negedge mclk) begin
    done_q <= fc_done;
    if (fc_done === 1'b1 && done_q === 1'b0 && exp_q.size() > 0) chk(fc_cnt, exp_q.pop_front(), 1'b1);
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {sleep, deep_lowpower_mode_req, rtc_alarm, gpio_wake, ring_osc_stop, cfg_load} = 6'h0;
    {xtal_en, fc_start, recov_clear, hold_gp1, cfg_in, fc_src, gen_sel, gen_div} = 81'h0;
    {gen_enable, gen_sleep_gate} = 12'hfff;
    d = $urandom(43);
    d = 1 + $urandom % 2;
    per[6] = 8 * d;
    tick(2);
    rst_n = 1'b1;
    tick();
    chk({ring_run, xtal_run}, 16'h2, 1'b0);
    xtal_en = 1'b1;
    gen_sel[3*`CCG_GEN_REF +: 3] = `CCG_SRC_CRYSTAL;
    gen_div[8*`CCG_GEN_SYS +: 8] = 8'(d);
    tick(20);
    for (int i = 0; i < 8; i++) run_fc(i, per[i]);
    gen_sel[5:3] = 3'h7;
    tick(30);
    run_fc(6, 8 * d);
    gen_sel[5:3] = `CCG_SRC_PLL_USB;
    tick(30);
    run_fc(6, 12 * d);
    for (int i = 0; i < 4; i++) gen_sel[3*(2+i) +: 3] = 3'(i);
    gen_sel[5:3] = `CCG_SRC_RING;
    tick(30);
    for (int i = 0; i < 4; i++) count_rises(i, per[i]);
    count_rises(4, per[1]);
    count_rises(5, per[1]);
    cfg_in = 8'($urandom);
    cfg_load = 1'b1;
    tick();
    cfg_load = 1'b0;
    tick(2);
    chk(16'(cfg), 16'(cfg_in), 1'b0);
    for (int w = 0; w < 2; w++) begin
      deep_lowpower_mode_req = 1'b1;
      tick();
      deep_lowpower_mode_req = 1'b0;
      tick(5);
      chk({deep, ring_run, xtal_run}, 16'h4, 1'b0);
      gen_div[15:8] = 8'h0;
      {rtc_alarm, gpio_wake} = w ? 2'b01 : 2'b10;
      tick();
      {rtc_alarm, gpio_wake} = 2'b00;
      tick(5);
      chk({deep, ring_run, xtal_run, cfg}, {5'h0, 3'h3, cfg_in}, 1'b0);
    end
    sleep = 1'b1;
    tick(10);
    chk({clk_sys, ring_run}, 16'h1, 1'b0);
    sleep = 1'b0;
    gen_sel[5:3] = `CCG_SRC_GPIN1;
    tick(30);
    hold_gp1 = 1'b1;
    tick(RCY + 30);
    chk(16'(recov), 16'h1, 1'b0);
    gen_sel[5:3] = `CCG_SRC_RING;
    hold_gp1 = 1'b0;
    recov_clear = 1'b1;
    tick();
    recov_clear = 1'b0;
    tick(2);
    chk(16'(recov), 16'h0, 1'b0);
    gen_sel[5:0] = {2{`CCG_SRC_CRYSTAL}};
    tick(30);
    ring_osc_stop = 1'b1;
    tick(3);
    chk(16'(ring_run), 16'h0, 1'b0);
    run_fc(6, 6);
    print_verdict();
  end
endmodule
`default_nettype wire
